// *** rtl/cache_test_pkg.sv ***
// constants shared by the cache self test and test access files
package cache_test_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int SET_W = 7;        // 128 sets
    localparam int WAY_W = 2;        // four entries per set
    localparam int TAG_W = 21;       // tag width
    localparam int WORD_W = 32;      // test register width
    localparam int LINE_W = 128;     // fill and read buffer width
    localparam int LRU_W = 3;        // pseudo lru bits per set
    localparam int IDX_W = SET_W + WAY_W;
    localparam logic [IDX_W-1:0] IDX_LAST = 9'h1FF;
    // ------------------------------------------------------------
    // test register numbers on the move instruction port
    // ------------------------------------------------------------
    localparam logic [2:0] TREG_DATA = 3'h3;
    localparam logic [2:0] TREG_STATUS = 3'h4;
    localparam logic [2:0] TREG_CONTROL = 3'h5;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_LSB = 0;
    localparam int ENT_LSB = 2;
    localparam int SET_LSB = 4;
    localparam int STS_VALIDS_LSB = 3;
    localparam int STS_LRU_LSB = 7;
    localparam int STS_VALID_BIT = 10;
    localparam int STS_TAG_LSB = 11;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // control field codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_BUF = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_FLUSH = 2'b11
    } op_e;
    // ------------------------------------------------------------
    // self test result bits and constants
    // ------------------------------------------------------------
    localparam int ACC_CACHE = 0;
    localparam int ACC_UNIT_LSB = 1;  // logic, rom, tlb at 1..3
    localparam int UNIT_N = 3;
    localparam logic [WORD_W-1:0] PAT_WORD = 32'hA5C3_5A3C;
    localparam logic PAT_LAST = 1'h1;
endpackage : cache_test_pkg

// *** rtl/cache_port_if.sv ***
// port between the test access logic and the cache arrays
`timescale 1ns/1ps
`default_nettype none
interface cache_port_if;
    import cache_test_pkg::*;
    logic req;                 // one-cycle operation strobe
    op_e op;                   // operation
    logic [SET_W-1:0] set;     // set select
    logic [WAY_W-1:0] way;     // entry select
    logic [LINE_W-1:0] wdata;  // line to write
    logic [TAG_W-1:0] wtag;    // tag to write
    logic wvalid;              // valid to write
    logic [LINE_W-1:0] rdata;  // addressed line
    logic [TAG_W-1:0] rtag;    // addressed tag
    logic rvalid;              // addressed valid
    logic [LRU_W-1:0] rlru;    // set lru bits
    logic [3:0] rvalids;       // set valid bits
    modport ctrl (output req, op, set, way, wdata, wtag, wvalid,
                  input rdata, rtag, rvalid, rlru, rvalids);
    modport arr (input req, op, set, way, wdata, wtag, wvalid,
                 output rdata, rtag, rvalid, rlru, rvalids);
endinterface : cache_port_if
`default_nettype wire

// *** rtl/cache_array.sv ***
// on-chip cache data, tag, valid and lru arrays
`timescale 1ns/1ps
`default_nettype none
module cache_array
    import cache_test_pkg::*;
#(
    parameter int SETS = 128,
    parameter int WAYS = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // operation port
    cache_port_if.arr port
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [LINE_W-1:0] data_mem [SETS*WAYS];  // data array, no reset
    logic [TAG_W-1:0] tag_mem [SETS*WAYS];    // tag array, no reset
    logic [WAYS-1:0] valid_mem [SETS];        // valid bits per set
    logic [LRU_W-1:0] lru_mem [SETS];         // pseudo lru per set
    logic [IDX_W-1:0] idx;                    // flat entry index

    assign idx = {port.set, port.way};

    // reads are combinational; the caller registers them
    assign port.rdata = data_mem[idx];
    assign port.rtag = tag_mem[idx];
    assign port.rvalid = valid_mem[port.set][port.way];
    assign port.rlru = lru_mem[port.set];
    assign port.rvalids = valid_mem[port.set];

    // data and tag only change on a cache write, never on flush
    always_ff @(posedge i_clk) begin
        if (port.req && port.op == OP_WRITE) begin
            data_mem[idx] <= port.wdata;
            tag_mem[idx] <= port.wtag;
        end
    end

    // valid and lru bits; written entries update lru as in normal use
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int s = 0; s < SETS; s++) begin
                valid_mem[s] <= '0;
                lru_mem[s] <= '0;
            end
        end else if (port.req && port.op == OP_FLUSH) begin
            for (int s = 0; s < SETS; s++) begin
                valid_mem[s] <= '0;
                lru_mem[s] <= '0;
            end
        end else if (port.req && port.op == OP_WRITE) begin
            valid_mem[port.set][port.way] <= port.wvalid;
            lru_mem[port.set][0] <= ~port.way[1];
            if (!port.way[1]) begin
                lru_mem[port.set][1] <= ~port.way[0];
            end else begin
                lru_mem[port.set][2] <= ~port.way[0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    AST_FLUSH_CLEARS: assert property (
        port.req && port.op == OP_FLUSH |=> lru_mem[0] == '0 && valid_mem[SETS-1] == '0
    ) else $error("flush left status bits set");
endmodule : cache_array
`default_nettype wire

// *** rtl/cache_self_test_access.sv ***
// self test entry, self test sequencer and cache test register access
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - no bus cycles while self test runs
// - result word zero means pass
// - reset then run normally after test
// - test logic, rom, cache and translation buffer
// - write, read, compare all 512 entries
// - separate 128-bit fill and read buffers
// - data staged through buffers only
// - buffers reached only via data register
// - four word accesses per buffer
// - cache read loads tag, valids, lru
// - set select picks one of 128
// - entry select: buffer word or way
// - control field decodes four operations
// - four test operations supported
// - registers reached only by move instructions
// - data write goes straight to fill word
// - 21-bit tag, valid at bit 10
// - flush clears lru and valid only
module cache_self_test_access
    import cache_test_pkg::*;
#(
    parameter int SETS = 128,
    parameter int WAYS = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // reset entry pins, asynchronous to i_clk
    input wire logic i_reset,
    input wire logic i_addr_hold_in,
    input wire logic i_flush_n,
    input wire logic i_addr_bit20_mask_in_n,
    // move to and from test register port
    input wire logic i_treg_wr,
    input wire logic i_treg_rd,
    input wire logic [2:0] i_treg_num,
    input wire logic [WORD_W-1:0] i_treg_wdata,
    output logic [WORD_W-1:0] o_treg_rdata,
    // unit self tests: logic, microcode rom, translation buffer
    output logic [UNIT_N-1:0] o_unit_start,
    input wire logic [UNIT_N-1:0] i_unit_done,
    input wire logic [UNIT_N-1:0] i_unit_fail,
    // core status
    output logic o_builtin_self_test_busy,
    output logic [WORD_W-1:0] o_accum,
    output logic o_core_reset,
    output logic o_bus_enable
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_RESET = 8'h01,   // reset pin held
        ST_RUN = 8'h02,     // normal operation
        ST_LOAD = 8'h04,    // stage pattern in fill buffer
        ST_WRITE = 8'h08,   // fill buffer to cache
        ST_READ = 8'h10,    // cache to read buffer
        ST_CHECK = 8'h20,   // compare read buffer
        ST_UNITS = 8'h40,   // other unit tests
        ST_FINISH = 8'h80   // internal reset after test
    } state_e;

    state_e state;                         // sequencer state
    logic [3:0] sync1;                     // first sync stage
    logic [3:0] sync2;                     // second sync stage
    logic [3:0] pins_prev;                 // sync2 one clock earlier
    logic rst_pin;                         // synchronised reset pin
    logic rst_fall;                        // reset pin released
    logic builtin_self_test_req;                        // pins ask for self test
    logic [WORD_W-1:0] fill_buf [4];       // cache fill buffer
    logic [WORD_W-1:0] read_buf [4];       // cache read buffer
    logic [WORD_W-1:0] status;             // cache status register
    logic [WORD_W-1:0] control;            // cache control register
    logic [IDX_W-1:0] idx;                 // self test entry index
    logic pat;                             // pattern pass number
    logic [LINE_W-1:0] pat_line;           // expected line
    logic [UNIT_N-1:0] unit_seen;          // units reported done
    logic sw_ok;                           // software may touch registers
    logic ctl_go;                          // control write starts op
    logic [WAY_W-1:0] ctl_ent;             // entry select in use
    logic mismatch;                        // compare failed
    cache_port_if port ();

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // each pin passes two flops; sync2 and its delayed copy pins_prev feed logic
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1 <= 4'h9;
            sync2 <= 4'h9;
            pins_prev <= 4'h9;
        end else begin
            sync1 <= {i_reset, i_addr_hold_in, i_flush_n, i_addr_bit20_mask_in_n};
            sync2 <= sync1;
            pins_prev <= sync2;
        end
    end

    assign rst_pin = sync2[3];
    assign rst_fall = pins_prev[3] && !sync2[3];
    // sampled strap pins
    // pins are taken from the clock before the reset fall
    assign builtin_self_test_req = pins_prev[2] && !pins_prev[1] && pins_prev[0];

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // reset then run
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_RESET;
        end else if (rst_pin) begin
            state <= ST_RESET;
        end else begin
            unique case (state)
                ST_RESET: begin
                    if (rst_fall) begin
                        state <= builtin_self_test_req ? ST_LOAD : ST_RUN;
                    end
                end
                ST_RUN: state <= ST_RUN;
                ST_LOAD: state <= ST_WRITE;
                ST_WRITE: state <= ST_READ;
                ST_READ: state <= ST_CHECK;
                ST_CHECK: begin
                    if (idx == IDX_LAST && pat == PAT_LAST) begin
                        state <= ST_UNITS;
                    end else begin
                        state <= ST_LOAD;
                    end
                end
                ST_UNITS: begin
                    if (&(unit_seen | i_unit_done)) begin
                        state <= ST_FINISH;
                    end
                end
                ST_FINISH: state <= ST_RUN;
            endcase
        end
    end

    // entry index and pattern pass
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            idx <= '0;
            pat <= 1'b0;
        end else if (state == ST_RESET) begin
            idx <= '0;
            pat <= 1'b0;
        end else if (state == ST_CHECK) begin
            idx <= IDX_W'(idx + 1'b1);
            if (idx == IDX_LAST) begin
                pat <= 1'b1;
            end
        end
    end

    // second pass uses the inverted constant so each bit sees both values
    assign pat_line = pat ? ~{4{PAT_WORD}} : {4{PAT_WORD}};
    assign mismatch = {read_buf[3], read_buf[2], read_buf[1], read_buf[0]} != pat_line
                      || status[STS_TAG_LSB +: TAG_W] != pat_line[TAG_W-1:0]
                      || !status[STS_VALID_BIT];

    // unit test starts and done capture
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            unit_seen <= '0;
            o_unit_start <= '0;
        end else begin
            o_unit_start <= (state == ST_CHECK && idx == IDX_LAST && pat == PAT_LAST) ? '1 : '0;
            unit_seen <= (state == ST_UNITS) ? (unit_seen | i_unit_done) : '0;
        end
    end

    // result accumulator
    // nonzero means a flaw; bits stick until the next self test
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_accum <= WORD_RST;
        end else if (state == ST_RESET && rst_fall && builtin_self_test_req) begin
            o_accum <= WORD_RST;
        end else if (state == ST_CHECK && mismatch) begin
            o_accum[ACC_CACHE] <= 1'b1;
        end else if (state == ST_UNITS) begin
            o_accum[ACC_UNIT_LSB +: UNIT_N] <= o_accum[ACC_UNIT_LSB +: UNIT_N] | (i_unit_done & i_unit_fail);
        end
    end

    // bus held off
    // bus opens one clock after normal operation starts
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bus_enable <= 1'b0;
            o_core_reset <= 1'b1;
        end else begin
            o_bus_enable <= (state == ST_RUN) && !rst_pin;
            o_core_reset <= rst_pin || (state == ST_FINISH);
        end
    end

    assign o_builtin_self_test_busy = state inside {ST_LOAD, ST_WRITE, ST_READ, ST_CHECK, ST_UNITS};

    // ------------------------------------------------------------
    // test register access
    // ------------------------------------------------------------
    // move instruction port only
    // software access is ignored while reset or self test owns the path
    assign sw_ok = (state == ST_RUN);
    assign ctl_go = sw_ok && i_treg_wr && i_treg_num == TREG_CONTROL;
    assign ctl_ent = control[ENT_LSB +: WAY_W];

    always_comb begin
        port.req = 1'b0;
        port.op = OP_BUF;
        port.set = i_treg_wdata[SET_LSB +: SET_W];
        port.way = i_treg_wdata[ENT_LSB +: WAY_W];
        if (o_builtin_self_test_busy) begin
            port.req = (state == ST_WRITE) || (state == ST_READ);
            port.op = (state == ST_WRITE) ? OP_WRITE : OP_READ;
            port.set = idx[IDX_W-1 -: SET_W];
            port.way = idx[WAY_W-1:0];
        end else if (ctl_go) begin
            port.req = i_treg_wdata[CTL_LSB +: 2] != OP_BUF;
            port.op = op_e'(i_treg_wdata[CTL_LSB +: 2]);
        end
    end

    assign port.wdata = {fill_buf[3], fill_buf[2], fill_buf[1], fill_buf[0]};
    assign port.wtag = status[STS_TAG_LSB +: TAG_W];
    assign port.wvalid = status[STS_VALID_BIT];

    // control register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            control <= WORD_RST;
        end else if (ctl_go) begin
            control <= i_treg_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int w = 0; w < 4; w++) begin
                fill_buf[w] <= WORD_RST;
            end
        end else if (state == ST_LOAD) begin
            for (int w = 0; w < 4; w++) begin
                fill_buf[w] <= pat_line[w*WORD_W +: WORD_W];
            end
        end else if (sw_ok && i_treg_wr && i_treg_num == TREG_DATA) begin
            fill_buf[ctl_ent] <= i_treg_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int w = 0; w < 4; w++) begin
                read_buf[w] <= WORD_RST;
            end
        end else if (port.req && port.op == OP_READ) begin
            for (int w = 0; w < 4; w++) begin
                read_buf[w] <= port.rdata[w*WORD_W +: WORD_W];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status <= WORD_RST;
        end else if (port.req && port.op == OP_READ) begin
            status <= {port.rtag, port.rvalid, port.rlru, port.rvalids, 3'h0};
        end else if (state == ST_LOAD) begin
            status <= {pat_line[TAG_W-1:0], 1'b1, 10'h000};
        end else if (sw_ok && i_treg_wr && i_treg_num == TREG_STATUS) begin
            status <= i_treg_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_treg_rdata <= WORD_RST;
        end else if (sw_ok && i_treg_rd) begin
            unique case (i_treg_num)
                TREG_DATA: o_treg_rdata <= read_buf[ctl_ent];
                TREG_STATUS: o_treg_rdata <= status;
                TREG_CONTROL: o_treg_rdata <= control;
                default: o_treg_rdata <= WORD_RST;
            endcase
        end
    end

    cache_array #(
        .SETS(SETS),
        .WAYS(WAYS)
    ) u_array (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .port(port)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence seq_finish;
        state == ST_FINISH && !rst_pin;
    endsequence
    sequence seq_internal_reset;
        o_core_reset ##1 (!o_core_reset && o_bus_enable);
    endsequence

    AST_BUS_QUIET: assert property (
        o_builtin_self_test_busy |-> ##1 !o_bus_enable
    ) else $error("bus enabled during self test");
    // core reset shows one clock after the finish state, bus opens the clock after that
    AST_RESET_AFTER: assert property (
        seq_finish ##1 !rst_pin |-> seq_internal_reset
    ) else $error("no internal reset after self test");
    AST_CACHE_FAIL: assert property (
        state == ST_CHECK && mismatch |=> o_accum[ACC_CACHE]
    ) else $error("cache flaw not recorded");
    AST_BUILTIN_SELF_TEST_START: assert property (
        state == ST_RESET && rst_fall && builtin_self_test_req && !sync2[3] |=> state == ST_LOAD ##1 state == ST_WRITE
    ) else $error("self test not started");
    AST_SWEEP_END: assert property (
        state == ST_CHECK && idx == IDX_LAST && pat && !rst_pin |=> state == ST_UNITS ##0 o_unit_start == '1
    ) else $error("sweep did not end after last entry");
    AST_FILL_WORD: assert property (
        sw_ok && i_treg_wr && i_treg_num == TREG_DATA |=> fill_buf[$past(ctl_ent)] == $past(i_treg_wdata)
    ) else $error("fill word not loaded");
    AST_READ_STATUS: assert property (
        port.req && port.op == OP_READ |=> status[STS_VALID_BIT] == $past(port.rvalid)
            && status[STS_TAG_LSB +: TAG_W] == $past(port.rtag)
    ) else $error("status not loaded by cache read");
    AST_BUF_READ: assert property (
        sw_ok && i_treg_rd && i_treg_num == TREG_DATA |=> o_treg_rdata == $past(read_buf[ctl_ent])
    ) else $error("read buffer word wrong");
endmodule : cache_self_test_access
`default_nettype wire

// *** test/unit_test_model.sv ***
// behavioural model of the logic, rom and translation buffer unit tests
`timescale 1ns/1ps
`default_nettype none
module unit_test_model
    import cache_test_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // start pulses and failure choice
    input wire logic [UNIT_N-1:0] i_start,
    input wire logic [UNIT_N-1:0] i_fail_mask,
    // answers
    output logic [UNIT_N-1:0] o_done,
    output logic [UNIT_N-1:0] o_fail
);
    logic [3:0] cnt [UNIT_N]; // per unit countdown
    // ----------------------------------------
    // each unit answers after its own delay
    // ----------------------------------------
    // unit test hooks
    always_ff @(posedge i_clk or negedge i_nrst) begin
        for (int u = 0; u < UNIT_N; u++) begin
            if (!i_nrst) begin
                cnt[u] <= 4'h0;
                o_done[u] <= 1'b0;
                o_fail[u] <= 1'b0;
            end else begin
                // unequal delays so dones arrive in different cycles
                if (i_start[u]) cnt[u] <= 4'(2 * u + 3);
                else if (cnt[u] != 4'h0) cnt[u] <= cnt[u] - 4'h1;
                o_done[u] <= (cnt[u] == 4'h1);
                // fail only means something with done, so show junk otherwise
                o_fail[u] <= (cnt[u] == 4'h1) ? i_fail_mask[u] : ~i_fail_mask[u];
            end
        end
    end
endmodule : unit_test_model
`default_nettype wire

// *** test/cache_self_test_access_tb_top.sv ***
// self-checking bench for the cache self test and test register access
`timescale 1ns/1ps
`default_nettype none
module cache_self_test_access_tb_top;
    import cache_test_pkg::*;
    // ----------------------------------------
    // stimulus, observed outputs, counters
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic rst_pin = 1'b1; // device reset pin
    logic hold = 1'b0; // address hold strap
    logic flush_n = 1'b1; // invalidate strap
    logic mask_n = 1'b1; // bit20 mask strap, high is deasserted
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] num = 3'h0;
    logic [WORD_W-1:0] wdata = WORD_RST;
    logic [UNIT_N-1:0] fail_mask = 3'h0;
    logic [WORD_W-1:0] rdata, accum;
    logic [UNIT_N-1:0] start, done, ufail;
    logic busy, core_rst, bus_en;
    int fails = 0;
    int samples_checked = 0;
    always #20 i_clk = ~i_clk;
    cache_self_test_access dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reset(rst_pin), .i_addr_hold_in(hold),
        .i_flush_n(flush_n), .i_addr_bit20_mask_in_n(mask_n), .i_treg_wr(wr), .i_treg_rd(rd), .i_treg_num(num),
        .i_treg_wdata(wdata), .o_treg_rdata(rdata), .o_unit_start(start), .i_unit_done(done),
        .i_unit_fail(ufail), .o_builtin_self_test_busy(busy), .o_accum(accum), .o_core_reset(core_rst), .o_bus_enable(bus_en));
    unit_test_model units (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(start), .i_fail_mask(fail_mask),
        .o_done(done), .o_fail(ufail));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one move-to-test-register instruction
    task automatic twr(input logic [2:0] n, input logic [WORD_W-1:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        num <= n;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : twr
    // one move-from-test-register instruction, masked compare
    task automatic trd(input logic [2:0] n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] m);
        @(posedge i_clk);
        rd <= 1'b1;
        num <= n;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask : trd
    // warm reset with or without the self test straps
    task automatic boot(input logic strap, input logic a20, input logic [UNIT_N-1:0] m, input logic [WORD_W-1:0] e);
        logic seen;
        logic pulsed;
        seen = 1'b0;
        pulsed = 1'b0;
        @(posedge i_clk);
        rst_pin <= 1'b1;
        hold <= strap;
        flush_n <= ~strap;
        // mask pin high asks for self test
        mask_n <= a20;
        fail_mask <= m;
        repeat (16) @(posedge i_clk);
        rst_pin <= 1'b0;
        @(posedge i_clk);
        hold <= 1'b0;
        flush_n <= 1'b1;
        mask_n <= 1'b1;
        for (int k = 0; k < 12000 && bus_en !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
            seen |= (busy === 1'b1);
            // internal reset must follow the self test
            pulsed |= seen && (core_rst === 1'b1);
            if (busy === 1'b1) chk({31'h0, bus_en}, 32'h0);
        end
        chk({31'h0, seen}, {31'h0, strap & a20});
        chk({31'h0, pulsed}, {31'h0, strap & a20});
        chk({30'h0, bus_en, core_rst}, 32'h2);
        chk(accum, e);
    endtask : boot
    task automatic results();
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        results();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        boot(1'b1, 1'b1, 3'h0, WORD_RST);
        // the core keeps the cache disabled from here on
        // last self test pass leaves inverted pattern in the last entry
        twr(TREG_CONTROL, 32'h7FE);
        twr(TREG_CONTROL, 32'hC);
        trd(TREG_DATA, ~PAT_WORD, '1);
        twr(TREG_CONTROL, 32'h3);
        for (int w = 0; w < 4; w++) begin
            twr(TREG_CONTROL, 32'(w << 2));
            twr(TREG_DATA, 32'hC0DE_0000 | 32'(w));
        end
        twr(TREG_STATUS, {21'h1B2C3, 1'b1, 10'h0});
        trd(TREG_STATUS, {21'h1B2C3, 1'b1, 10'h0}, '1);
        twr(TREG_CONTROL, 32'h7F9);
        twr(TREG_CONTROL, 32'h7FA);
        // lru bits are left out: their update order is internal
        trd(TREG_STATUS, {21'h1B2C3, 1'b1, 3'h0, 4'h4, 3'h0}, ~32'h380);
        for (int w = 0; w < 4; w++) begin
            twr(TREG_CONTROL, 32'(w << 2));
            trd(TREG_DATA, 32'hC0DE_0000 | 32'(w), '1);
        end
        twr(TREG_CONTROL, 32'h7FF);
        twr(TREG_CONTROL, 32'h7FA);
        trd(TREG_STATUS, {21'h1B2C3, 11'h0}, '1);
        twr(TREG_CONTROL, 32'h8);
        trd(TREG_DATA, 32'hC0DE_0002, '1);
        trd(3'h6, WORD_RST, '1);
        boot(1'b1, 1'b1, 3'h2, 32'h1 << (ACC_UNIT_LSB + 1));
        boot(1'b0, 1'b1, 3'h0, 32'h1 << (ACC_UNIT_LSB + 1));
        // straps set but mask pin asserted: no self test, result kept
        boot(1'b1, 1'b0, 3'h0, 32'h1 << (ACC_UNIT_LSB + 1));
        results();
    end
endmodule : cache_self_test_access_tb_top
`default_nettype wire
